//--- core/sync_out_pkg.sv
// Purpose: shared constants, types and timing tables for the sync output stage
// Assumes: pixel clock is clk_sys; controls come from the serial control register bank
// Notes: the offsets are two's complement, positive delays an edge
// Notes on behaviour
// (RULE_01) core horizontal sync drives horizontal sync pin
// (RULE_02) vertical pin: vsync, or field when selected
// (RULE_03) data-enable pin: active region, or field when selected
// (RULE_04) field can leave on either shared pin
// (RULE_05) default edge positions follow current video standard
// (RULE_06) seven offsets: two 10-bit, five 4-bit
// (RULE_07) offsets signed: negative advances, positive delays
// (RULE_08) three controls invert hsync, field, vsync outputs
// (RULE_09) hsync start offset: signed pixel clock count
// (RULE_10) zero keeps edge; 0x001-0x1FF move later
// (RULE_11) 0x200-0x3FF move earlier, up to 512 clocks
// (RULE_12) standard-definition horizontal defaults per table
// (RULE_13) high-definition horizontal defaults per table
// (RULE_14) graphics horizontal defaults per table
// (RULE_15) hsync end offset uses same signed encoding
// (RULE_16) vertical offsets: signed 4-bit line counts
// (RULE_17) shifted edge equals default plus signed offset
package sync_out_pkg;

    // ****************************************
    // register map and reset values
    // ****************************************
    localparam logic [7:0] HSYNC_START_OFFSET_ADDR = 8'h7c;
    localparam logic [9:0] HS_OFFSET_RESET = 10'h000;
    localparam logic [3:0] LINE_OFFSET_RESET = 4'h0;

    // ****************************************
    // timing constants
    // ****************************************
    localparam int unsigned PIXEL_PERIOD_NS = 40;
    localparam logic [11:0] HS_LEAD_POS = 12'h000;
    localparam logic [11:0] VS_START_LINE = 12'h000;
    localparam logic [11:0] VS_LINES_PROG = 12'h005;
    localparam logic [11:0] VS_LINES_INTL = 12'h003;
    localparam logic [11:0] FIELD_TOGGLE_LINE = 12'h000;
    localparam logic [11:0] COUNT_MAX = 12'hfff;

    typedef enum logic [3:0] {
        STD_525I = 4'h0, STD_625I = 4'h1, STD_525P = 4'h2, STD_625P = 4'h3,
        STD_720P = 4'h4, STD_1080I = 4'h5, STD_1080P = 4'h6,
        STD_VGA60 = 4'h7, STD_SVGA60 = 4'h8, STD_XGA60 = 4'h9
    } video_std_t;

    typedef struct packed {
        logic [11:0] sync_to_active;
        logic [11:0] width;
        logic [11:0] total;
    } h_timing_t;

    // default horizontal timing, indexed by video_std_t, 1x output
    localparam h_timing_t H_TABLE [10] = '{
        '{12'h076, 12'h040, 12'h35a}, '{12'h080, 12'h040, 12'h360},
        '{12'h074, 12'h040, 12'h35a}, '{12'h07e, 12'h040, 12'h360},
        '{12'h100, 12'h028, 12'h672}, '{12'h0bc, 12'h02c, 12'h898},
        '{12'h076, 12'h02c, 12'h898}, '{12'h08c, 12'h060, 12'h320},
        '{12'h0d4, 12'h080, 12'h420}, '{12'h124, 12'h088, 12'h540}
    };

    typedef struct packed {
        logic [9:0] hsync_start_offset;
        logic [9:0] hsync_end_offset;
        logic [3:0] vsync_start_offset;
        logic [3:0] vsync_end_offset;
        logic [3:0] vsync_even_start_offset;
        logic [3:0] even_field_toggle_offset;
        logic [3:0] odd_field_toggle_offset;
        logic hsync_polarity_invert;
        logic field_polarity_invert;
        logic vsync_polarity_invert;
        logic field_on_vertical_pin_select;
        logic field_on_de_select;
    } sync_ctrl_t;

    typedef struct packed {
        logic line_start;
        logic frame_start;
        logic active;
        logic field;
    } core_timing_t;

    typedef struct packed {
        logic hsync;
        logic shared_vertical_pin;
        logic de;
    } sync_pins_t;

    function automatic logic [12:0] sext10(input logic [9:0] v);
        sext10 = {{3{v[9]}}, v};
    endfunction : sext10

    function automatic logic [12:0] sext4(input logic [3:0] v);
        sext4 = {{9{v[3]}}, v};
    endfunction : sext4

    function automatic logic interlaced(input video_std_t s);
        interlaced = (s == STD_525I) || (s == STD_625I) || (s == STD_1080I);
    endfunction : interlaced

endpackage : sync_out_pkg

//--- core/sync_edge_wrap.sv
// Purpose: default position plus signed offset, wrapped into one period
// Assumes: offset already sign extended to 13 bits, modulus not zero
// Notes: combinational, so the edge moves in the same cycle the offset changes
`timescale 1ns/100ps
module sync_edge_wrap (
    input wire logic [11:0] base,
    input wire logic [12:0] offset,
    input wire logic [11:0] modulus,
    output logic [11:0] pos
);
    import sync_out_pkg::*;

    logic [13:0] sum;

    always_comb begin
        sum = {2'b00, base} + {offset[12], offset}; // [RULE_17]
        if (sum[13]) begin
            pos = 12'(sum + {2'b00, modulus});
        end else if (sum[12:0] >= {1'b0, modulus}) begin
            pos = 12'(sum - {2'b00, modulus});
        end else begin
            pos = sum[11:0];
        end
    end

endmodule : sync_edge_wrap

//--- core/sync_output_positioning.sv
// Purpose: place, invert and route hsync, vsync and field, and route data enable, onto pins
// Assumes: core timing arrives on clk_sys; line_start marks nominal hsync leading edge
// Notes: vertical edges change at the shifted hsync leading edge of the matching line
`timescale 1ns/100ps
module sync_output_positioning (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire sync_out_pkg::video_std_t video_std,
    input wire sync_out_pkg::core_timing_t core_timing,
    input wire sync_out_pkg::sync_ctrl_t ctrl,
    output sync_out_pkg::sync_pins_t pins
);
    import sync_out_pkg::*;

    // ****************************************
    // counters and measured field length
    // ****************************************
    logic [11:0] pix;
    logic [11:0] next_pix;
    logic [11:0] line;
    logic [11:0] next_line;
    logic [11:0] field_len;
    logic [11:0] next_field_len;
    h_timing_t ht;
    logic [11:0] vs_lines;

    always_comb begin
        ht = H_TABLE[video_std]; // [RULE_05] [RULE_12] [RULE_13] [RULE_14]
        vs_lines = interlaced(video_std) ? VS_LINES_INTL : VS_LINES_PROG;
        next_pix = pix;
        next_line = line;
        next_field_len = field_len;
        if (core_timing.line_start) begin
            next_pix = HS_LEAD_POS;
            if (core_timing.frame_start) begin
                next_line = 12'h000;
                next_field_len = 12'(line + 12'h001);
            end else if (line != COUNT_MAX) begin
                next_line = 12'(line + 12'h001);
            end
        end else if (pix != COUNT_MAX) begin
            next_pix = 12'(pix + 12'h001);
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pix <= 12'h000;
            line <= 12'h000;
            field_len <= COUNT_MAX;
        end else begin
            pix <= next_pix;
            line <= next_line;
            field_len <= next_field_len;
        end
    end

    // ****************************************
    // shifted edge positions
    // ****************************************
    logic [11:0] hs_start_pos;
    logic [11:0] hs_end_pos;
    logic [11:0] vs_start_pos;
    logic [11:0] vs_end_pos;
    logic [11:0] fld_pos;
    logic [3:0] vs_start_sel;
    logic [3:0] fld_sel;

    assign vs_start_sel = core_timing.field ? ctrl.vsync_even_start_offset
                                            : ctrl.vsync_start_offset;
    assign fld_sel = core_timing.field ? ctrl.odd_field_toggle_offset
                                       : ctrl.even_field_toggle_offset;

    sync_edge_wrap u_hs_start (
        .base(HS_LEAD_POS),
        .offset(sext10(ctrl.hsync_start_offset)), // [RULE_09] [RULE_10] [RULE_11]
        .modulus(ht.total),
        .pos(hs_start_pos)
    );
    sync_edge_wrap u_hs_end (
        .base(ht.width),
        .offset(sext10(ctrl.hsync_end_offset)), // [RULE_15]
        .modulus(ht.total),
        .pos(hs_end_pos)
    );
    sync_edge_wrap u_vs_start (
        .base(VS_START_LINE),
        .offset(sext4(vs_start_sel)), // [RULE_16] [RULE_06]
        .modulus(field_len),
        .pos(vs_start_pos)
    );
    sync_edge_wrap u_vs_end (
        .base(vs_lines),
        .offset(sext4(ctrl.vsync_end_offset)), // [RULE_16]
        .modulus(field_len),
        .pos(vs_end_pos)
    );
    sync_edge_wrap u_field (
        .base(FIELD_TOGGLE_LINE),
        .offset(sext4(fld_sel)), // [RULE_07]
        .modulus(field_len),
        .pos(fld_pos)
    );

    // ****************************************
    // sync state
    // ****************************************
    logic hs_state;
    logic next_hs_state;
    logic vs_state;
    logic next_vs_state;
    logic field_q;
    logic next_field_q;
    logic line_tick;
    sync_pins_t next_pins;

    assign line_tick = (pix == hs_start_pos);

    always_comb begin
        next_hs_state = hs_state;
        next_vs_state = vs_state;
        next_field_q = field_q;
        if (pix == hs_start_pos) begin
            next_hs_state = 1'b1; // [RULE_01]
        end else if (pix == hs_end_pos) begin
            next_hs_state = 1'b0;
        end
        if (line_tick) begin
            if (line == vs_start_pos) begin
                next_vs_state = 1'b1;
            end else if (line == vs_end_pos) begin
                next_vs_state = 1'b0;
            end
            if (line == fld_pos) begin
                next_field_q = core_timing.field;
            end
        end
        next_pins.hsync = hs_state ^ ctrl.hsync_polarity_invert; // [RULE_08]
        next_pins.shared_vertical_pin = ctrl.field_on_vertical_pin_select
            ? (field_q ^ ctrl.field_polarity_invert)
            : (vs_state ^ ctrl.vsync_polarity_invert); // [RULE_02] [RULE_04]
        next_pins.de = ctrl.field_on_de_select
            ? (field_q ^ ctrl.field_polarity_invert)
            : core_timing.active; // [RULE_03] [RULE_04]
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            hs_state <= 1'b0;
            vs_state <= 1'b0;
            field_q <= 1'b0;
            pins <= '0;
        end else begin
            hs_state <= next_hs_state;
            vs_state <= next_vs_state;
            field_q <= next_field_q;
            pins <= next_pins;
        end
    end

    // ****************************************
    // checks
    // ****************************************
    AST_HS_LEAD_EDGE: assert property ( // [RULE_09]
        @(posedge clk_sys) disable iff (!rst_n)
        (pix == hs_start_pos) |=> hs_state ##1 (pins.hsync != $past(ctrl.hsync_polarity_invert)))
        else $error("hsync did not start at its shifted leading edge");

    AST_HS_TRAIL_EDGE: assert property ( // [RULE_15]
        @(posedge clk_sys) disable iff (!rst_n)
        (pix == hs_end_pos && pix != hs_start_pos) |=> !hs_state)
        else $error("hsync did not end at its shifted trailing edge");

    AST_HS_ZERO_OFFSET: assert property ( // [RULE_10]
        @(posedge clk_sys) disable iff (!rst_n)
        (ctrl.hsync_start_offset == 10'h000) |-> (hs_start_pos == HS_LEAD_POS))
        else $error("zero start offset moved the leading edge");

    AST_HS_ONE_EARLIER: assert property ( // [RULE_11]
        @(posedge clk_sys) disable iff (!rst_n)
        (ctrl.hsync_start_offset == 10'h3ff) |-> (hs_start_pos == 12'(ht.total - 12'h001)))
        else $error("offset 0x3FF is not one pixel clock earlier");

    AST_HS_DEFAULT_WIDTH: assert property ( // [RULE_12]
        @(posedge clk_sys) disable iff (!rst_n)
        (ctrl.hsync_end_offset == 10'h000) |-> (hs_end_pos == ht.width))
        else $error("default trailing edge is not at the standard width");

    AST_VS_PIN_ROUTE: assert property ( // [RULE_02]
        @(posedge clk_sys) disable iff (!rst_n)
        !ctrl.field_on_vertical_pin_select |=>
            (pins.shared_vertical_pin == ($past(vs_state) ^ $past(ctrl.vsync_polarity_invert))))
        else $error("vertical pin does not carry vsync");

    AST_DE_FIELD_ROUTE: assert property ( // [RULE_03]
        @(posedge clk_sys) disable iff (!rst_n)
        ctrl.field_on_de_select |=>
            (pins.de == ($past(field_q) ^ $past(ctrl.field_polarity_invert))))
        else $error("data-enable pin does not carry field when selected");

    AST_VS_LINE_START: assert property ( // [RULE_16]
        @(posedge clk_sys) disable iff (!rst_n)
        (line_tick && line == vs_start_pos) |=> vs_state ##1
            (ctrl.field_on_vertical_pin_select || $past(ctrl.vsync_polarity_invert)
             || pins.shared_vertical_pin))
        else $error("vsync did not start on its shifted line");

endmodule : sync_output_positioning

//--- tb/sync_sink_model.sv
// Purpose: downstream receiver model that logs where sync edges land
// Assumes: line and frame markers come from the bench timing source
// Notes: positions are pixel counts since the last line_start and line counts since the last frame_start
`timescale 1ns/100ps
module sync_sink_model (
    input wire logic clk_sys,
    input wire logic line_start,
    input wire logic frame_start,
    input wire sync_out_pkg::sync_pins_t pins,
    output logic [11:0] hs_rise,
    output logic [11:0] hs_fall,
    output logic [11:0] vs_rise,
    output logic [11:0] vs_fall
);
    import sync_out_pkg::*;
    logic [11:0] pix = 12'h000;
    logic [11:0] line = 12'h000;
    sync_pins_t last = '0;
    // ****************************************
    // edge logging
    // ****************************************
    always @(posedge clk_sys) begin
        last <= pins;
        pix <= line_start ? 12'h000 : pix + 12'h001;
        if (line_start) begin
            line <= frame_start ? 12'h000 : line + 12'h001;
        end
        if (pins.hsync && !last.hsync) hs_rise <= pix;
        if (!pins.hsync && last.hsync) hs_fall <= pix;
        if (pins.shared_vertical_pin && !last.shared_vertical_pin) vs_rise <= line;
        if (!pins.shared_vertical_pin && last.shared_vertical_pin) vs_fall <= line;
    end
endmodule : sync_sink_model

//--- tb/sync_output_positioning_test.sv
// Purpose: self-checking bench for sync_output_positioning
// Assumes: bench makes line, frame, active and field timing
// Notes: fields are 8 lines long to keep the run short
`timescale 1ns/100ps
module sync_output_positioning_test;
    import sync_out_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    video_std_t video_std = STD_VGA60;
    sync_ctrl_t ctrl = '0;
    core_timing_t core_timing;
    sync_pins_t pins;
    logic act = 1'b0;
    logic fld = 1'b0;
    logic [11:0] hcnt = 12'h000;
    logic [11:0] vcnt = 12'h000;
    logic [11:0] hs_rise, hs_fall, vs_rise, vs_fall;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    int wid [10] = '{64, 64, 64, 64, 40, 44, 44, 96, 128, 136};
    int tot [10] = '{858, 864, 858, 864, 1650, 2200, 2200, 800, 1056, 1344};
    logic [9:0] hs0 [6] = '{10'h001, 10'h100, 10'h1ff, 10'h3ff, 10'h3fe, 10'h200};
    logic [9:0] he0 [6] = '{10'h005, 10'h3ff, 10'h200, 10'h000, 10'h1ff, 10'h100};
    // start, end, expected rise line, expected fall line
    logic [15:0] vt [4] = '{16'h0005, 16'h2e23, 16'hf075, 16'h0053};
    // ****************************************
    // clock, timing source and instances
    // ****************************************
    always #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        hcnt <= (hcnt >= 12'(tot[video_std] - 1)) ? 12'h000 : hcnt + 12'h001;
        if (hcnt >= 12'(tot[video_std] - 1)) vcnt <= (vcnt == 12'h007) ? 12'h000 : vcnt + 12'h001;
        if (cycles == 98000) begin
            miscompares++;
            conclude();
        end
    end
    assign core_timing = '{line_start: hcnt == 12'h000, frame_start: hcnt == 12'h000
        && vcnt == 12'h000, active: act, field: fld};
    sync_output_positioning DUT (.clk_sys(clk_sys), .rst_n(rst_n), .video_std(video_std),
        .core_timing(core_timing), .ctrl(ctrl), .pins(pins));
    sync_sink_model sink (.clk_sys(clk_sys), .line_start(core_timing.line_start),
        .frame_start(core_timing.frame_start), .pins(pins), .hs_rise(hs_rise),
        .hs_fall(hs_fall), .vs_rise(vs_rise), .vs_fall(vs_fall));
    // ****************************************
    // helpers
    // ****************************************
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic lines(input int n);
        repeat (n) begin
            @(posedge clk_sys);
            while (hcnt != 12'h000) @(posedge clk_sys);
        end
    endtask : lines
    // returns at the line start edge of the first line of a field
    task automatic frame;
        lines(1);
        while (vcnt != 12'h000) lines(1);
    endtask : frame
    // pin edge seen two clocks after the pixel where the edge sits
    function automatic logic [11:0] hexp(input int base, input int off, input int t);
        hexp = 12'((base + off + 2 + 2 * t) % t);
    endfunction : hexp
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_defaults;
        for (int s = 0; s < 10; s++) begin
            video_std <= video_std_t'(s);
            lines(1);
            check(hs_rise, hexp(0, 0, tot[s]));
            check(hs_fall, hexp(wid[s], 0, tot[s]));
        end
        $display("test defaults done");
    endtask : t_defaults
    task automatic t_hoffsets;
        sync_ctrl_t c;
        c = '0;
        video_std <= STD_VGA60;
        for (int i = 0; i < 6; i++) begin
            c.hsync_start_offset = hs0[i];
            c.hsync_end_offset = he0[i];
            ctrl <= c;
            lines(2);
            check(hs_rise, hexp(0, $signed(hs0[i]), 800));
            check(hs_fall, hexp(96, $signed(he0[i]), 800));
        end
        c = '0;
        c.hsync_polarity_invert = 1'b1;
        ctrl <= c;
        lines(2);
        check(hs_fall, hexp(0, 0, 800));
        check(hs_rise, hexp(96, 0, 800));
        $display("test horizontal offsets done");
    endtask : t_hoffsets
    task automatic t_vertical;
        sync_ctrl_t c;
        for (int i = 0; i < 4; i++) begin
            c = '0;
            c.vsync_start_offset = vt[i][15:12];
            c.vsync_end_offset = vt[i][11:8];
            if (i == 3) begin
                fld <= 1'b1;
                c.vsync_polarity_invert = 1'b1;
                c.vsync_even_start_offset = 4'h3;
            end
            ctrl <= c;
            // first field lets a stale vsync level settle, second one logs clean edges
            lines(16);
            check(vs_rise, 12'(vt[i][7:4]));
            check(vs_fall, 12'(vt[i][3:0]));
        end
        $display("test vertical offsets done");
    endtask : t_vertical
    task automatic t_route;
        sync_ctrl_t c;
        c = '0;
        ctrl <= c;
        act <= 1'b1;
        lines(2);
        check(12'(pins.de), 12'h001);
        // active is low while field is routed, so a wrong route shows
        c.field_on_de_select = 1'b1;
        c.field_on_vertical_pin_select = 1'b1;
        ctrl <= c;
        act <= 1'b0;
        frame();
        check(12'(pins.de), 12'h001);
        check(12'(pins.shared_vertical_pin), 12'h001);
        // vsync is low at field start, inverted it would read high
        c.field_polarity_invert = 1'b1;
        c.vsync_polarity_invert = 1'b1;
        ctrl <= c;
        act <= 1'b1;
        frame();
        check(12'(pins.de), 12'h000);
        check(12'(pins.shared_vertical_pin), 12'h000);
        $display("test pin routing done");
    endtask : t_route
    task automatic conclude;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude
    initial begin
        repeat (6) @(posedge clk_sys);
        rst_n <= 1'b1;
        // first line after reset is partial, so start on a clean line
        lines(1);
        t_defaults();
        t_hoffsets();
        t_vertical();
        t_route();
        conclude();
    end
endmodule : sync_output_positioning_test
